//--- hw/dre_engine.sv
// Purpose: Decimation, equalization and rate resampling engine with power-mode control.
// Assumes: i_mclk is the modulator clock; modulator samples arrive as signed words.
// Notes: Standby and sleep freeze the data path by logic; the clock keeps running.
`timescale 1ns/1ns
module dre_engine (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [8:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_power_down_pin,
  input wire logic i_mod_valid,
  input wire logic [15:0] i_mod_data,
  output logic o_mod_ready,
  output logic o_sample_valid,
  output logic [15:0] o_sample,
  output logic o_data_oe_n,
  output logic o_analog_on,
  output logic o_clock_on,
  output logic o_ref_on,
  output logic o_driver_on
);
  localparam int DW = dre_pkg::DRE_DW;
  localparam int AW = dre_pkg::DRE_AW;
  localparam int CICW = dre_pkg::DRE_CICW;

  typedef enum logic [4:0] {
    DRE_S_WAIT = 5'b00001,
    DRE_S_A = 5'b00010,
    DRE_S_B = 5'b00100,
    DRE_S_C = 5'b01000,
    DRE_S_D = 5'b10000
  } dre_state_e;

  function automatic logic signed [DW-1:0] dre_sat(input logic signed [AW-1:0] v);
    if (v > 40'sh0000007FFF) begin
      return 16'sh7FFF;
    end else if (v < 40'shFFFFFF8000) begin
      return 16'sh8000;
    end
    return v[DW-1:0];
  endfunction : dre_sat

  // ---------------------------------------------------------------
  // Registers and power mode
  // ---------------------------------------------------------------
  logic [7:0] power_mode_control, bandwidth_select_control, resampler_factor_control;
  logic [7:0] next_power, next_bw, next_factor, next_rdata;
  logic serial_used, next_serial_used;
  logic [1:0] mode, bw_stages;
  logic [5:0] output_divide_factor;
  logic run, active;

  assign bw_stages = bandwidth_select_control[dre_pkg::DRE_BW_MSB:dre_pkg::DRE_BW_LSB];
  assign output_divide_factor = resampler_factor_control[dre_pkg::DRE_FACTOR_MSB:0];
  // The pin only rules while software has never touched the register port.
  assign mode = serial_used ? power_mode_control[dre_pkg::DRE_PWR_MSB:0] :
                (i_power_down_pin ? dre_pkg::DRE_PM_POWER_DOWN_PIN : dre_pkg::DRE_PM_NORMAL);
  assign run = (mode == dre_pkg::DRE_PM_NORMAL) || (mode == dre_pkg::DRE_PM_POWER_DOWN_PIN);
  assign active = run && (output_divide_factor != 6'h00);

  always_comb begin
    next_power = power_mode_control;
    next_bw = bandwidth_select_control;
    next_factor = resampler_factor_control;
    next_serial_used = serial_used || i_reg_wr || i_reg_rd;
    next_rdata = 8'h00;
    if (i_reg_wr) begin
      case (i_reg_addr)
        dre_pkg::DRE_OFF_POWER: next_power = i_reg_wdata;
        dre_pkg::DRE_OFF_BW: next_bw = i_reg_wdata;
        dre_pkg::DRE_OFF_FACTOR: next_factor = i_reg_wdata;
        default: next_power = power_mode_control;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        dre_pkg::DRE_OFF_POWER: next_rdata = power_mode_control;
        dre_pkg::DRE_OFF_BW: next_rdata = bandwidth_select_control;
        dre_pkg::DRE_OFF_FACTOR: begin
          next_rdata = {1'b0, 1'b0, output_divide_factor};
          next_rdata[dre_pkg::DRE_RUN_BIT] = active;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      power_mode_control <= dre_pkg::DRE_POWER_RST;
      bandwidth_select_control <= dre_pkg::DRE_BW_RST;
      resampler_factor_control <= dre_pkg::DRE_FACTOR_RST;
      serial_used <= 1'b0;
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
      o_analog_on <= 1'b1;
      o_clock_on <= 1'b1;
      o_ref_on <= 1'b1;
      o_driver_on <= 1'b1;
      o_data_oe_n <= 1'b0;
    end else begin
      power_mode_control <= next_power;
      bandwidth_select_control <= next_bw;
      resampler_factor_control <= next_factor;
      serial_used <= next_serial_used;
      o_reg_rdata <= next_rdata;
      o_reg_rvalid <= i_reg_rd;
      o_analog_on <= (mode == dre_pkg::DRE_PM_NORMAL);
      o_clock_on <= run;
      o_ref_on <= (mode != dre_pkg::DRE_PM_SLEEP);
      o_driver_on <= (mode != dre_pkg::DRE_PM_SLEEP);
      o_data_oe_n <= !run;
    end
  end

  // ---------------------------------------------------------------
  // Sinc3 decimate-by-2 cascade
  // ---------------------------------------------------------------
  logic s_v [0:dre_pkg::DRE_CIC_STAGES];
  logic signed [DW-1:0] s_d [0:dre_pkg::DRE_CIC_STAGES];
  logic in_take;

  assign in_take = i_mod_valid && o_mod_ready;
  assign s_v[0] = in_take;
  assign s_d[0] = i_mod_data;

  for (genvar g = 0; g < dre_pkg::DRE_CIC_STAGES; g++) begin : g_cic
    logic signed [CICW-1:0] i1, i2, i3, z1, z2, z3, xin, c1, c2, c3;
    logic signed [CICW-1:0] next_i1, next_i2, next_i3, next_z1, next_z2, next_z3;
    logic ph, next_ph, ov, next_ov, used;
    logic signed [DW-1:0] od, next_od;

    assign used = (bw_stages > 2'(g));
    assign xin = {{(CICW-DW){s_d[g][DW-1]}}, s_d[g]};
    always_comb begin
      {next_i1, next_i2, next_i3} = {i1, i2, i3};
      {next_z1, next_z2, next_z3} = {z1, z2, z3};
      {c1, c2, c3} = {z1, z2, z3};
      next_ph = ph;
      next_ov = 1'b0;
      next_od = od;
      if (s_v[g]) begin
        next_i1 = i1 + xin;
        next_i2 = i2 + next_i1;
        next_i3 = i3 + next_i2;
        next_ph = ~ph;
        if (ph) begin
          c1 = next_i3 - z1;
          c2 = c1 - z2;
          c3 = c2 - z3;
          next_z1 = next_i3;
          next_z2 = c1;
          next_z3 = c2;
          next_ov = 1'b1;
          next_od = c3[DW+dre_pkg::DRE_CIC_SHIFT-1:dre_pkg::DRE_CIC_SHIFT];
        end
      end
    end
    always_ff @(posedge i_mclk) begin
      if (i_rst || !used) begin
        {i1, i2, i3, z1, z2, z3} <= '0;
        ph <= 1'b0;
        ov <= 1'b0;
        od <= '0;
      end else begin
        {i1, i2, i3, z1, z2, z3} <= {next_i1, next_i2, next_i3, next_z1, next_z2, next_z3};
        ph <= next_ph;
        ov <= next_ov;
        od <= next_od;
      end
    end
    assign s_v[g+1] = used ? ov : s_v[g];
    assign s_d[g+1] = used ? od : s_d[g];
  end

  // ---------------------------------------------------------------
  // Quarter-rate decimator and equalizing band filter
  // ---------------------------------------------------------------
  logic signed [DW-1:0] qd [0:dre_pkg::DRE_QUARTER_RATE_DECIMATOR_TAPS-1];
  logic signed [DW-1:0] next_qd [0:dre_pkg::DRE_QUARTER_RATE_DECIMATOR_TAPS-1];
  logic signed [DW-1:0] eq [0:dre_pkg::DRE_EQZ_TAPS-1];
  logic signed [DW-1:0] next_eq [0:dre_pkg::DRE_EQZ_TAPS-1];
  logic signed [AW-1:0] dec_sum, eqz_sum;
  logic [1:0] dcnt, next_dcnt;
  logic dec_fire, next_dec_fire, eqz_fire;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic signed [DW-1:0] fifo_out_data, eqz_word;
  logic [2:0] fifo_level;

  always_comb begin
    next_qd = qd;
    next_eq = eq;
    next_dcnt = dcnt;
    next_dec_fire = 1'b0;
    dec_sum = '0;
    eqz_sum = '0;
    for (int k = 0; k < dre_pkg::DRE_QUARTER_RATE_DECIMATOR_TAPS; k++) begin
      dec_sum = dec_sum + dre_pkg::DRE_QUARTER_RATE_DECIMATOR_H[(k < 12) ? k : 22 - k] * qd[k];
    end
    for (int k = 0; k < dre_pkg::DRE_EQZ_TAPS; k++) begin
      eqz_sum = eqz_sum + dre_pkg::DRE_EQZ_H[(k < 32) ? k : 62 - k] * eq[k];
    end
    if (s_v[dre_pkg::DRE_CIC_STAGES]) begin
      for (int k = dre_pkg::DRE_QUARTER_RATE_DECIMATOR_TAPS - 1; k > 0; k--) begin
        next_qd[k] = qd[k-1];
      end
      next_qd[0] = s_d[dre_pkg::DRE_CIC_STAGES];
      next_dcnt = dcnt + 1'b1;
      next_dec_fire = (dcnt == dre_pkg::DRE_QUARTER_RATE_DECIMATOR_LAST);
    end
    if (dec_fire) begin
      for (int k = dre_pkg::DRE_EQZ_TAPS - 1; k > 0; k--) begin
        next_eq[k] = eq[k-1];
      end
      next_eq[0] = dre_sat(dec_sum >>> dre_pkg::DRE_QUARTER_RATE_DECIMATOR_SHIFT);
    end
  end

  assign eqz_word = dre_sat(eqz_sum >>> dre_pkg::DRE_EQZ_SHIFT);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      qd <= '{default: '0};
      eq <= '{default: '0};
      dcnt <= 2'h0;
      dec_fire <= 1'b0;
      eqz_fire <= 1'b0;
      o_mod_ready <= 1'b0;
    end else begin
      qd <= next_qd;
      eq <= next_eq;
      dcnt <= next_dcnt;
      dec_fire <= next_dec_fire;
      eqz_fire <= dec_fire;
      // Margin of one word covers the sample already in flight when ready drops.
      o_mod_ready <= run && fifo_in_ready && (fifo_level < dre_pkg::DRE_READY_LEVEL);
    end
  end

  dre_fifo #(.W(DW), .DEPTH(dre_pkg::DRE_FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_in_valid(eqz_fire),
    .o_in_ready(fifo_in_ready),
    .i_in_data(eqz_word),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data),
    .o_level(fifo_level)
  );

  // ---------------------------------------------------------------
  // Rate resampler: two half-band interpolators and a phase accumulator
  // ---------------------------------------------------------------
  logic signed [DW-1:0] d1 [0:dre_pkg::DRE_FIRST_INTERPOLATOR_TAPS-1];
  logic signed [DW-1:0] next_d1 [0:dre_pkg::DRE_FIRST_INTERPOLATOR_TAPS-1];
  logic signed [DW-1:0] e2 [0:dre_pkg::DRE_SECOND_INTERPOLATOR_TAPS-1];
  logic signed [DW-1:0] next_e2 [0:dre_pkg::DRE_SECOND_INTERPOLATOR_TAPS-1];
  logic signed [AW-1:0] first_interpolator_sum, second_interpolator_sum;
  logic signed [DW-1:0] first_interpolator_a, second_interpolator_a, interp, next_interp, e2_in, next_sample;
  logic e2_shift, next_sample_valid;
  dre_state_e state, next_state;
  logic [6:0] acc, next_acc, acc_sum, k_half;

  assign fifo_pop = active && fifo_out_valid &&
                    ((state == DRE_S_D) || (state == DRE_S_WAIT));
  assign first_interpolator_a = dre_sat(first_interpolator_sum >>> dre_pkg::DRE_FIRST_INTERPOLATOR_SHIFT);
  assign second_interpolator_a = dre_sat(second_interpolator_sum >>> dre_pkg::DRE_SECOND_INTERPOLATOR_SHIFT);
  assign k_half = (7'(output_divide_factor) <= dre_pkg::DRE_FACTOR_FLOOR) ?
                  dre_pkg::DRE_FACTOR_FLOOR : 7'(output_divide_factor);
  assign acc_sum = acc + dre_pkg::DRE_ACC_STEP;

  always_comb begin
    next_d1 = d1;
    next_e2 = e2;
    next_state = state;
    next_interp = interp;
    e2_shift = 1'b0;
    e2_in = first_interpolator_a;
    first_interpolator_sum = '0;
    second_interpolator_sum = '0;
    for (int k = 0; k < dre_pkg::DRE_FIRST_INTERPOLATOR_TAPS; k++) begin
      first_interpolator_sum = first_interpolator_sum + dre_pkg::DRE_FIRST_INTERPOLATOR_H[(k < 7) ? k : 13 - k] * d1[k];
    end
    for (int k = 0; k < dre_pkg::DRE_SECOND_INTERPOLATOR_TAPS; k++) begin
      second_interpolator_sum = second_interpolator_sum + dre_pkg::DRE_SECOND_INTERPOLATOR_H[(k < 4) ? k : 7 - k] * e2[k];
    end
    case (state)
      DRE_S_WAIT: next_state = fifo_pop ? DRE_S_A : DRE_S_WAIT;
      DRE_S_A: begin
        next_interp = e2[dre_pkg::DRE_SECOND_INTERPOLATOR_MID];
        e2_shift = 1'b1;
        next_state = DRE_S_B;
      end
      DRE_S_B: begin
        next_interp = second_interpolator_a;
        next_state = DRE_S_C;
      end
      DRE_S_C: begin
        next_interp = e2[dre_pkg::DRE_SECOND_INTERPOLATOR_MID];
        e2_shift = 1'b1;
        e2_in = d1[dre_pkg::DRE_FIRST_INTERPOLATOR_MID];
        next_state = DRE_S_D;
      end
      DRE_S_D: begin
        next_interp = second_interpolator_a;
        next_state = fifo_pop ? DRE_S_A : DRE_S_WAIT;
      end
      default: next_state = DRE_S_WAIT;
    endcase
    if (!run) begin
      next_state = state;
      next_interp = interp;
      e2_shift = 1'b0;
    end
    if (fifo_pop) begin
      for (int k = dre_pkg::DRE_FIRST_INTERPOLATOR_TAPS - 1; k > 0; k--) begin
        next_d1[k] = d1[k-1];
      end
      next_d1[0] = fifo_out_data;
    end
    if (e2_shift) begin
      for (int k = dre_pkg::DRE_SECOND_INTERPOLATOR_TAPS - 1; k > 0; k--) begin
        next_e2[k] = e2[k-1];
      end
      next_e2[0] = e2_in;
    end
    next_acc = acc_sum;
    next_sample_valid = 1'b0;
    next_sample = o_sample;
    if (acc_sum >= k_half) begin
      next_acc = (acc_sum - k_half >= k_half) ? 7'h00 : acc_sum - k_half;
      next_sample_valid = 1'b1;
      next_sample = interp;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || (run && !active)) begin
      d1 <= '{default: '0};
      e2 <= '{default: '0};
      interp <= '0;
      state <= DRE_S_WAIT;
      acc <= 7'h00;
      o_sample_valid <= 1'b0;
      o_sample <= 16'h0000;
    end else if (!run) begin
      o_sample_valid <= 1'b0;
    end else begin
      d1 <= next_d1;
      e2 <= next_e2;
      interp <= next_interp;
      state <= next_state;
      acc <= next_acc;
      o_sample_valid <= next_sample_valid;
      o_sample <= next_sample;
    end
  end
endmodule : dre_engine

//--- hw/dre_pkg.sv
// Purpose: Constants, register map and filter coefficients of the decimation engine.
// Assumes: One clock, the modulator clock, drives every register of the engine.
// Notes: Coefficient tables hold the first half of each symmetric filter.
package dre_pkg;
  // ---------------------------------------------------------------
  // Widths and register map
  // ---------------------------------------------------------------
  localparam int DRE_DW = 16;
  localparam int DRE_CW = 18;
  localparam int DRE_AW = 40;
  localparam int DRE_CICW = 19;
  localparam int DRE_CIC_SHIFT = 3;
  localparam int DRE_CIC_STAGES = 2;
  localparam logic [8:0] DRE_OFF_POWER = 9'h008;
  localparam logic [8:0] DRE_OFF_BW = 9'h00F;
  localparam logic [8:0] DRE_OFF_FACTOR = 9'h101;
  localparam int DRE_BW_LSB = 5;
  localparam int DRE_BW_MSB = 6;
  localparam int DRE_PWR_MSB = 1;
  localparam int DRE_FACTOR_MSB = 5;
  localparam int DRE_RUN_BIT = 7;
  localparam logic [7:0] DRE_POWER_RST = 8'h00;
  localparam logic [7:0] DRE_BW_RST = 8'h00;
  localparam logic [7:0] DRE_FACTOR_RST = 8'h00;
  localparam logic [1:0] DRE_PM_NORMAL = 2'h0;
  localparam logic [1:0] DRE_PM_POWER_DOWN_PIN = 2'h1;
  localparam logic [1:0] DRE_PM_STANDBY = 2'h2;
  localparam logic [1:0] DRE_PM_SLEEP = 2'h3;
  // ---------------------------------------------------------------
  // Resampler and buffering
  // ---------------------------------------------------------------
  localparam logic [6:0] DRE_FACTOR_FLOOR = 7'h08;
  localparam logic [6:0] DRE_ACC_STEP = 7'h02;
  localparam int DRE_FIFO_DEPTH = 4;
  localparam logic [2:0] DRE_READY_LEVEL = 3'h3;
  // ---------------------------------------------------------------
  // Filters
  // ---------------------------------------------------------------
  localparam int DRE_QUARTER_RATE_DECIMATOR_TAPS = 23;
  localparam int DRE_QUARTER_RATE_DECIMATOR_SHIFT = 15;
  localparam logic [1:0] DRE_QUARTER_RATE_DECIMATOR_LAST = 2'h3;
  localparam int DRE_EQZ_TAPS = 63;
  localparam int DRE_EQZ_SHIFT = 16;
  localparam int DRE_FIRST_INTERPOLATOR_TAPS = 14;
  localparam int DRE_FIRST_INTERPOLATOR_SHIFT = 15;
  localparam int DRE_FIRST_INTERPOLATOR_MID = 6;
  localparam int DRE_SECOND_INTERPOLATOR_TAPS = 8;
  localparam int DRE_SECOND_INTERPOLATOR_SHIFT = 13;
  localparam int DRE_SECOND_INTERPOLATOR_MID = 3;
  localparam logic signed [DRE_CW-1:0] DRE_QUARTER_RATE_DECIMATOR_H [0:11] = '{
    -21, 0, 122, 0, -418, 0, 1121, 0, -2796, 0, 10184, 16384};
  localparam logic signed [DRE_CW-1:0] DRE_EQZ_H [0:31] = '{
    17, 31, -15, -52, 36, 78, -84, -98, 170, 97, -291, -42, 441, -98, -592, 353,
    694, -744, -677, 1271, 450, -1909, 103, 2612, -1147, -3326, 3022, 4051,
    -6870, -5305, 21141, 38956};
  // Even-position taps only; the odd centre tap becomes a plain pass of the mid sample.
  localparam logic signed [DRE_CW-1:0] DRE_FIRST_INTERPOLATOR_H [0:6] = '{
    15, -97, 361, -1017, 2450, -5761, 20433};
  localparam logic signed [DRE_CW-1:0] DRE_SECOND_INTERPOLATOR_H [0:3] = '{-27, 227, -1032, 4928};
endpackage : dre_pkg

//--- hw/dre_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Data out shows the oldest entry whenever valid is high.
`timescale 1ns/1ns
module dre_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [LW-1:0] level, next_level;
  logic push, pop;

  assign o_in_ready = (level < LW'(DEPTH));
  assign o_out_valid = (level != '0);
  assign o_out_data = mem[rd_ptr];
  assign o_level = level;
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_level = level;
    if (push && !pop) begin
      next_level = level + 1'b1;
    end else if (pop && !push) begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule : dre_fifo

//--- verification/dre_engine_sva.sv
// Purpose: Concurrent checks on the ports of the decimation engine.
// Assumes: One clock domain; i_rst is synchronous and active high.
// Notes: Attached to every engine instance by the bind below.
`timescale 1ns/1ns
module dre_engine_sva (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [8:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_power_down_pin,
  input wire logic i_mod_valid,
  input wire logic [15:0] i_mod_data,
  input wire logic o_mod_ready,
  input wire logic o_sample_valid,
  input wire logic [15:0] o_sample,
  input wire logic o_data_oe_n,
  input wire logic o_analog_on,
  input wire logic o_clock_on,
  input wire logic o_ref_on,
  input wire logic o_driver_on
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence pwr_wr(logic [1:0] m);
    i_reg_wr && i_reg_addr == dre_pkg::DRE_OFF_POWER && i_reg_wdata[1:0] == m;
  endsequence
  sequence fac_wr(logic [5:0] c);
    i_reg_wr && i_reg_addr == dre_pkg::DRE_OFF_FACTOR && i_reg_wdata[5:0] == c;
  endsequence
  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read got no answer");
  rd_idle_a: assert property (!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00)
    else $error("read data shown without a read");
  mode_normal_a: assert property (pwr_wr(2'h0) |-> ##[1:2] (o_analog_on && o_clock_on && o_ref_on))
    else $error("normal mode not all on");
  mode_standby_a: assert property (pwr_wr(2'h2) |-> ##[1:2] (!o_clock_on && o_ref_on && o_driver_on && o_data_oe_n))
    else $error("standby levels wrong");
  mode_sleep_a: assert property (pwr_wr(2'h3) |-> ##[1:2] (!o_ref_on && !o_driver_on && !o_analog_on))
    else $error("sleep levels wrong");
  mode_order_a: assert property ((o_data_oe_n != o_clock_on) && (o_ref_on == o_driver_on) && (!o_analog_on || o_clock_on) && (!o_clock_on || o_ref_on))
    else $error("power outputs inconsistent");
  quiet_off_a: assert property (!o_clock_on ##1 !o_clock_on |-> !o_sample_valid && !o_mod_ready)
    else $error("activity while clocks are off");
  pulse_gap_a: assert property (o_sample_valid |=> !o_sample_valid [*3])
    else $error("output pulses closer than four cycles");
  zero_stop_a: assert property (fac_wr(6'h00) |-> ##3 !o_sample_valid [*8])
    else $error("output pulse with factor zero");
  fac_start_a: assert property (fac_wr(6'h08) ##0 o_clock_on |-> ##[1:8] o_sample_valid)
    else $error("no output after factor set");
endmodule : dre_engine_sva
bind dre_engine dre_engine_sva u_sva (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_power_down_pin(i_power_down_pin),
  .i_mod_valid(i_mod_valid), .i_mod_data(i_mod_data), .o_mod_ready(o_mod_ready),
  .o_sample_valid(o_sample_valid), .o_sample(o_sample), .o_data_oe_n(o_data_oe_n),
  .o_analog_on(o_analog_on), .o_clock_on(o_clock_on), .o_ref_on(o_ref_on),
  .o_driver_on(o_driver_on));

//--- verification/dre_sample_sink.sv
// Purpose: Receiver logic that captures output samples of the engine.
// Assumes: Samples are taken on the rising clock edge while valid is high.
// Notes: Keeps a running count and the last captured value.
`timescale 1ns/1ns
module dre_sample_sink (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [15:0] i_sample,
  output logic [15:0] o_count,
  output logic [15:0] o_last
);
  logic [15:0] next_count;
  logic [15:0] next_last;
  always_comb begin
    next_count = o_count;
    next_last = o_last;
    if (i_valid) begin
      next_count = o_count + 16'h0001;
      next_last = i_sample;
    end
  end
  always_ff @(posedge i_mclk) begin
    o_count <= i_rst ? 16'h0000 : next_count;
    o_last <= i_rst ? 16'h0000 : next_last;
  end
endmodule : dre_sample_sink

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the decimation engine.
// Assumes: Inputs change at the falling clock edge.
// Notes: Pin power-down check first, then register rows, rate, stream, standby, restart and reset cases.
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] outs;
  } dre_row_s;
  logic i_mclk, i_rst, i_reg_wr, i_reg_rd, i_power_down_pin, i_mod_valid;
  logic [8:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, d;
  logic [15:0] i_mod_data, o_sample, count, last, n0;
  logic o_reg_rvalid, o_mod_ready, o_sample_valid, o_data_oe_n;
  logic o_analog_on, o_clock_on, o_ref_on, o_driver_on;
  logic signed [16:0] diff;
  wire logic [4:0] outs = {o_analog_on, o_clock_on, o_ref_on, o_driver_on, o_data_oe_n};
  int bad_count = 0;
  int comparisons = 0;
  int expn;
  dre_row_s rows [10] = '{'{9'h008, 8'h00, 8'h00, 5'h1E}, '{9'h008, 8'h01, 8'h01, 5'h0E},
    '{9'h008, 8'h02, 8'h02, 5'h07}, '{9'h101, 8'h08, 8'h08, 5'h07},
    '{9'h008, 8'h03, 8'h03, 5'h01}, '{9'h008, 8'h70, 8'h70, 5'h1E},
    '{9'h101, 8'h08, 8'h88, 5'h1E}, '{9'h00F, 8'h60, 8'h60, 5'h1E},
    '{9'h0AA, 8'h5A, 8'h00, 5'h1E}, '{9'h101, 8'h00, 8'h00, 5'h1E}};
  logic [5:0] codes [5] = '{6'h01, 6'h08, 6'h09, 6'h10, 6'h3F};
  logic [15:0] dcs [3] = '{16'h1000, 16'hF000, 16'h0800};
  dre_engine u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_power_down_pin(i_power_down_pin),
    .i_mod_valid(i_mod_valid), .i_mod_data(i_mod_data), .o_mod_ready(o_mod_ready),
    .o_sample_valid(o_sample_valid), .o_sample(o_sample), .o_data_oe_n(o_data_oe_n),
    .o_analog_on(o_analog_on), .o_clock_on(o_clock_on), .o_ref_on(o_ref_on),
    .o_driver_on(o_driver_on));
  dre_sample_sink u_sink (.i_mclk(i_mclk), .i_rst(i_rst), .i_valid(o_sample_valid),
    .i_sample(o_sample), .o_count(count), .o_last(last));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : tick
  task automatic reg_wr(input logic [8:0] a, input logic [7:0] v);
    tick(1);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = v;
    tick(1);
    i_reg_wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [8:0] a, output logic [7:0] v);
    tick(1);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    tick(1);
    i_reg_rd = 1'b0;
    check(16'(o_reg_rvalid), 16'h0001, "read valid");
    v = o_reg_rdata;
  endtask : reg_rd
  task automatic wait_pulse();
    int i;
    for (i = 0; i < 40 && o_sample_valid !== 1'b1; i++) begin
      tick(1);
    end
    if (i == 40) begin
      bad_count++;
      end_sim();
    end
  endtask : wait_pulse
  initial begin
    {i_rst, i_power_down_pin} = 2'h3;
    {i_reg_wr, i_reg_rd, i_mod_valid, i_reg_addr, i_reg_wdata, i_mod_data} = '0;
    tick(3);
    i_rst = 1'b0;
    tick(4);
    check(16'(outs), 16'h000E, "pin power-down");
    i_power_down_pin = 1'b0;
    foreach (rows[i]) begin
      reg_wr(rows[i].addr, rows[i].wdata);
      tick(2);
      reg_rd(rows[i].addr, d);
      check(16'(d), 16'(rows[i].rdata), "register");
      check(16'(outs), 16'(rows[i].outs), "power pins");
    end
    foreach (codes[i]) begin
      reg_wr(9'h101, 8'h00);
      tick(16);
      reg_wr(9'h101, {2'h0, codes[i]});
      wait_pulse();
      n0 = count;
      tick(504);
      expn = 1008 / ((codes[i] <= 6'h08) ? 8 : int'(codes[i]));
      n0 = count - n0;
      check(16'(int'(n0) >= expn - 1 && int'(n0) <= expn + 1), 16'h0001, "rate");
    end
    reg_wr(9'h101, 8'h08);
    i_mod_valid = 1'b1;
    for (int b = 0; b < 3; b++) begin
      reg_wr(9'h00F, {1'b0, 2'(b), 5'h00});
      i_mod_data = dcs[b];
      tick(4000);
      diff = 17'($signed(last)) - 17'($signed(dcs[b]));
      check(16'(diff >= -17'sd16 && diff <= 17'sd16), 16'h0001, "dc gain");
    end
    reg_wr(9'h008, 8'h02);
    tick(3);
    n0 = count;
    tick(40);
    check(count - n0, 16'h0000, "standby pulses");
    check(16'(o_mod_ready), 16'h0000, "standby ready");
    reg_wr(9'h008, 8'h00);
    reg_wr(9'h101, 8'h00);
    tick(16);
    reg_wr(9'h101, 8'h08);
    wait_pulse();
    tick(20);
    check(16'(count - n0 >= 16'h0003), 16'h0001, "restart pulses");
    i_rst = 1'b1;
    tick(3);
    i_rst = 1'b0;
    check(16'(outs), 16'h001E, "reset pins");
    reg_rd(9'h101, d);
    check(16'(d), 16'h0000, "reset factor");
    end_sim();
  end
endmodule : tb_top
